// >>> dv/epiu_core_model.sv
// Core dispatch model that takes vectors for the unit's requests.
`timescale 1ns/1ps

module epiu_core_model (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ack_en,
    input  wire logic [1:0]          ack_dly,
    input  wire epiu_pkg::epiu_irq_t irq_request,
    output epiu_pkg::epiu_irq_t      vector_taken
);
    // ==========================================================
    // Dispatch
    logic [1:0] wait_ff;
    logic [3:0] req;

    assign req = irq_request;

    // The core serves one vector at a time, the lowest first, after a chosen delay.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_ff      <= 2'h0;
            vector_taken <= 4'h0;
        end else if (vector_taken != 4'h0 || !ack_en || req == 4'h0) begin
            wait_ff      <= 2'h0;
            vector_taken <= 4'h0;
        end else if (wait_ff == ack_dly) begin
            wait_ff      <= 2'h0;
            vector_taken <= req & ~(req - 4'h1);
        end else begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
endmodule

// >>> dv/tb_epiu_ext_irq.sv
// Self-checking bench for the external pin interrupt unit.
`timescale 1ns/1ps

module tb_epiu_ext_irq;
    logic                          hclk = 1'b0;
    logic                          hresetn = 1'b0;
    logic                          hsel = 1'b0;
    logic                          hwrite = 1'b0;
    logic [epiu_pkg::ADDR_W-1:0]   haddr = 12'h000;
    logic [1:0]                    htrans = 2'h0;
    logic [31:0]                   hwdata = 32'h0;
    logic [31:0]                   hrdata;
    logic [31:0]                   rdq;
    logic [31:0]                   q;
    logic                          hreadyout;
    logic                          hresp;
    logic                          wake;
    logic                          pin_a = 1'b0;
    logic                          pin_b = 1'b0;
    logic                          gie = 1'b0;
    logic                          ack_en = 1'b0;
    logic [1:0]                    ack_dly = 2'h0;
    logic [15:0]                   pins = 16'h0;
    epiu_pkg::epiu_irq_t           vector_taken;
    epiu_pkg::epiu_irq_t           irq_request;
    int                            miscompares = 0;
    int                            n_checks = 0;
    localparam logic [11:0] ADRS [8] = '{epiu_pkg::ADDR_SENSE, epiu_pkg::ADDR_ENABLE,
        epiu_pkg::ADDR_FLAGS, epiu_pkg::ADDR_BANK_EN, epiu_pkg::ADDR_BANK_FLAGS,
        epiu_pkg::ADDR_MASK_LOW, epiu_pkg::ADDR_MASK_HIGH, 12'h004};
    localparam logic [31:0] KEEP [8] = '{32'hf, 32'h3, 32'h0, 32'h3, 32'h0, 32'hff, 32'hff, 32'h0};

    always #25 hclk = ~hclk;
    always_ff @(posedge hclk) rdq <= hrdata;

    epiu_ext_irq i_epiu_ext_irq (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .request_line_a(pin_a),
        .request_line_b(pin_b), .change_watch_pin(pins), .global_int_enable(gie),
        .vector_taken(vector_taken), .irq_request(irq_request), .wake_request(wake));
    epiu_core_model i_epiu_core_model (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
        .ack_dly(ack_dly), .irq_request(irq_request), .vector_taken(vector_taken));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Address phase until hready, then data phase until hready; read data taken there.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= epiu_pkg::HTRANS_NONSEQ;
        for (n = 0; n < 1 || (hreadyout !== 1'b1 && n < 50); n++) @(posedge hclk);
        if (n >= 50) begin
            miscompares++;
            conclude();
        end
        htrans <= 2'h0;
        hwdata <= d;
        for (n = 0; n < 1 || (hreadyout !== 1'b1 && n < 50); n++) @(posedge hclk);
        #1 q = rdq;
        chk("hresp", 32'(epiu_pkg::HRESP_OKAY), 32'(hresp));
        if (n >= 50) begin
            miscompares++;
            conclude();
        end
    endtask

    function automatic logic trig(input logic [1:0] c, input logic o, input logic n);
        case (c)
            2'h1: return o != n;
            2'h2: return o & !n;
            2'h3: return !o & n;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        logic [31:0] d;
        logic [15:0] np;
        logic [15:0] df;
        logic [7:0]  m0;
        logic [7:0]  m1;
        logic        na;
        logic        nb;
        logic [1:0]  c;
        int          n;
        void'($urandom(97));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(0, ADRS[i], 32'h0);
            chk("reset value", 32'h0, q);
            d = $urandom;
            bus(1, ADRS[i], d);
            bus(0, ADRS[i], 32'h0);
            chk("readback", d & KEEP[i], q);
        end
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            c = 2'(i % 3 + 1);
            na = 1'($urandom);
            nb = 1'($urandom);
            bus(1, epiu_pkg::ADDR_SENSE, {28'h0, c, c});
            bus(1, epiu_pkg::ADDR_FLAGS, 32'h3);
            d = {30'h0, trig(c, pin_b, nb), trig(c, pin_a, na)};
            @(posedge hclk);
            pin_a <= na;
            pin_b <= nb;
            repeat (4) @(posedge hclk);
            bus(1, epiu_pkg::ADDR_FLAGS, 32'h0);
            bus(0, epiu_pkg::ADDR_FLAGS, 32'h0);
            chk("line flags", d, q);
            bus(1, epiu_pkg::ADDR_FLAGS, 32'h3);
            bus(0, epiu_pkg::ADDR_FLAGS, 32'h0);
            chk("flags cleared", 32'h0, q);
        end
        $display("test edges done");
        bus(1, epiu_pkg::ADDR_SENSE, 32'h0);
        bus(1, epiu_pkg::ADDR_ENABLE, 32'h3);
        // The source holds line B low for the whole check.
        @(posedge hclk);
        pin_a <= 1'b1;
        pin_b <= 1'b0;
        gie   <= 1'b1;
        repeat (4) @(posedge hclk);
        #1 chk("level request", 32'h2, {30'h0, irq_request.line_b, irq_request.line_a});
        chk("wake request", 32'h1, 32'(wake));
        bus(0, epiu_pkg::ADDR_FLAGS, 32'h0);
        chk("level flags", 32'h0, q);
        @(posedge hclk);
        gie <= 1'b0;
        repeat (2) @(posedge hclk);
        #1 chk("global gate", 32'h0, {30'h0, irq_request.line_b, irq_request.line_a});
        $display("test level done");
        bus(1, epiu_pkg::ADDR_SENSE, 32'hb);
        @(posedge hclk);
        pin_a <= 1'b0;
        pin_b <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(1, epiu_pkg::ADDR_FLAGS, 32'h3);
        @(posedge hclk);
        pin_a   <= 1'b1;
        pin_b   <= 1'b0;
        gie     <= 1'b1;
        ack_en  <= 1'b1;
        ack_dly <= 2'($urandom);
        for (n = 0; n < 10 && irq_request.line_a !== 1'b1; n++) begin
            @(posedge hclk);
            #1;
        end
        chk("vector raised", 32'h1, 32'(irq_request.line_a));
        for (n = 0; n < 30 && irq_request !== 4'h0; n++) begin
            @(posedge hclk);
            #1;
        end
        chk("vector taken", 32'h0, 32'(irq_request));
        bus(0, epiu_pkg::ADDR_FLAGS, 32'h0);
        chk("flags after vector", 32'h0, q);
        $display("test vectors done");
        ack_en <= 1'b0;
        bus(1, epiu_pkg::ADDR_ENABLE, 32'h0);
        bus(1, epiu_pkg::ADDR_BANK_EN, 32'h3);
        for (int i = 0; i < 8; i++) begin
            m0 = (i == 0) ? 8'hff : 8'($urandom);
            m1 = (i == 0) ? 8'h00 : 8'($urandom);
            np = 16'($urandom);
            bus(1, epiu_pkg::ADDR_MASK_LOW, {24'h0, m0});
            bus(1, epiu_pkg::ADDR_MASK_HIGH, {24'h0, m1});
            bus(1, epiu_pkg::ADDR_BANK_FLAGS, 32'h3);
            df = pins ^ np;
            d = {30'h0, |(df[15:8] & m1), |(df[7:0] & m0)};
            @(posedge hclk);
            pins <= np;
            #1 chk("wake request", 32'(|d), 32'(wake));
            repeat (4) @(posedge hclk);
            bus(0, epiu_pkg::ADDR_BANK_FLAGS, 32'h0);
            chk("bank flags", d, q);
            chk("bank request", d, {30'h0, irq_request.high_bank, irq_request.low_bank});
        end
        // The pin change is timed so that its set lands on the write-one edge.
        bus(1, epiu_pkg::ADDR_MASK_LOW, 32'hff);
        bus(1, epiu_pkg::ADDR_MASK_HIGH, 32'hff);
        @(posedge hclk);
        pins <= ~pins;
        bus(1, epiu_pkg::ADDR_BANK_FLAGS, 32'h3);
        bus(0, epiu_pkg::ADDR_BANK_FLAGS, 32'h0);
        chk("set beats clear", 32'h3, q);
        @(posedge hclk);
        ack_en <= 1'b1;
        for (n = 0; n < 30 && irq_request !== 4'h0; n++) begin
            @(posedge hclk);
            #1;
        end
        bus(0, epiu_pkg::ADDR_BANK_FLAGS, 32'h0);
        chk("bank vectors", 32'h0, q);
        $display("test banks done");
        conclude();
    end
endmodule

// >>> rtl/epiu_ext_irq.sv
// External request lines and pin-change banks with an AHB-Lite register slave.
//
// Operation
// - Reserved bits of sense, enable, flag and bank registers read as zero.
// - Sense register holds line B field in bits 3:2, line A in 1:0.
// - Sense codes: 00 low level, 01 any change, 10 falling, 11 rising.
// - A line requests only when global enable and its own enable are set.
// - Pins are sampled before edge detection; pulses over one clock are caught.
// - Pin activity raises requests regardless of the pin's direction.
// - Enable register: line B in bit 1, line A in bit 0, own vectors.
// - Triggering edge or change sets the line flag, B bit 1, A bit 0.
// - Flag plus enable plus global enable raises the vector request.
// - Every flag clears when hardware enters its interrupt routine.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - A line in low-level mode always reads its flag as cleared.
// - Bank enable: high bank bit 1, low bank bit 0; enabled changes interrupt.
// - Any change on an unmasked bank pin sets that bank flag, high bit 1, low bit 0.
// - Mask registers gate each pin's change detection; masks reset to zero.
// - Pin-change detection also works asynchronously for wake-up.
// - Edges need the clock; low-level detection works without it.
// - Enabled low-level mode keeps requesting while the pin stays low.
`timescale 1ns/1ps

module epiu_ext_irq (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [epiu_pkg::ADDR_W-1:0]   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [epiu_pkg::DATA_W-1:0]   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic [epiu_pkg::DATA_W-1:0]        hrdata,
    output logic                               hresp,
    input  wire logic                          request_line_a,
    input  wire logic                          request_line_b,
    input  wire logic [15:0]                   change_watch_pin,
    input  wire logic                          global_int_enable,
    input  wire epiu_pkg::epiu_irq_t           vector_taken,
    output epiu_pkg::epiu_irq_t                irq_request,
    output logic                               wake_request
);

    // ==========================================================
    // Helper functions

    // True when the synchronised sample pair shows the event chosen by mode.
    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic       cur,
                                      input logic       prev);
        logic hit;
        hit = 1'b0;
        unique case (epiu_pkg::epiu_sense_t'(mode))
            epiu_pkg::SENSE_LOW:  hit = 1'b0;
            epiu_pkg::SENSE_ANY:  hit = cur ^ prev;
            epiu_pkg::SENSE_FALL: hit = prev & ~cur;
            epiu_pkg::SENSE_RISE: hit = cur & ~prev;
        endcase
        return hit;
    endfunction

    function automatic logic bank_hit(input logic [7:0] cur,
                                      input logic [7:0] prev,
                                      input logic [7:0] mask);
        return |((cur ^ prev) & mask);
    endfunction

    function automatic logic addr_is(input epiu_pkg::epiu_ahb_ap_t ap,
                                     input logic [epiu_pkg::ADDR_W-1:0] a);
        return ap.valid && ap.write && (ap.addr == a);
    endfunction

    // ==========================================================
    // Pin synchronisers

    logic [epiu_pkg::NUM_PINS-1:0] meta_ff;
    logic [epiu_pkg::NUM_PINS-1:0] sync_ff;
    logic [epiu_pkg::NUM_PINS-1:0] prev_ff;
    logic [epiu_pkg::NUM_PINS-1:0] nxt_meta;
    logic [epiu_pkg::NUM_PINS-1:0] nxt_sync;
    logic [epiu_pkg::NUM_PINS-1:0] nxt_prev;

    // Pins are read whatever their direction, so software can drive them to
    // raise its own requests.
    // direction independent
    always_comb begin
        nxt_meta = {change_watch_pin, request_line_b, request_line_a};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // ==========================================================
    // AHB-Lite address phase capture

    epiu_pkg::epiu_ahb_ap_t ap_ff;
    epiu_pkg::epiu_ahb_ap_t nxt_ap;
    logic [epiu_pkg::DATA_W-1:0] hrdata_ff;
    logic [epiu_pkg::DATA_W-1:0] nxt_hrdata;
    logic                        ap_take;

    // The slave never stalls, so every transfer has a zero-wait data phase.
    assign hreadyout = 1'b1;
    assign hresp     = epiu_pkg::HRESP_OKAY;
    assign hrdata    = hrdata_ff;
    assign ap_take   = hsel && hready && htrans[1];

    always_comb begin
        nxt_ap.valid = ap_take;
        nxt_ap.write = hwrite;
        nxt_ap.addr  = haddr;
    end

    // ==========================================================
    // Registers

    logic [3:0] sense_ff;
    logic [1:0] enable_ff;
    logic [1:0] flags_ff;
    logic [1:0] bank_en_ff;
    logic [1:0] bank_flags_ff;
    logic [7:0] mask_low_ff;
    logic [7:0] mask_high_ff;
    logic [3:0] nxt_sense;
    logic [1:0] nxt_enable;
    logic [1:0] nxt_flags;
    logic [1:0] nxt_bank_en;
    logic [1:0] nxt_bank_flags;
    logic [7:0] nxt_mask_low;
    logic [7:0] nxt_mask_high;
    logic [1:0] line_set;
    logic [1:0] line_clr;
    logic [1:0] line_low;
    logic [1:0] bank_set;
    logic [1:0] bank_clr;
    logic [1:0] sense_a;
    logic [1:0] sense_b;
    logic       wr_any;

    assign sense_a = sense_ff[epiu_pkg::SENSE_A_LSB +: 2];
    assign sense_b = sense_ff[epiu_pkg::SENSE_B_LSB +: 2];
    assign wr_any  = ap_ff.valid && ap_ff.write;

    always_comb begin
        nxt_sense      = sense_ff;
        nxt_enable     = enable_ff;
        nxt_bank_en    = bank_en_ff;
        nxt_mask_low   = mask_low_ff;
        nxt_mask_high  = mask_high_ff;
        if (addr_is(ap_ff, epiu_pkg::ADDR_SENSE)) begin
            nxt_sense = hwdata[3:0];
        end
        if (addr_is(ap_ff, epiu_pkg::ADDR_ENABLE)) begin
            nxt_enable = hwdata[1:0];
        end
        if (addr_is(ap_ff, epiu_pkg::ADDR_BANK_EN)) begin
            nxt_bank_en = hwdata[1:0];
        end
        if (addr_is(ap_ff, epiu_pkg::ADDR_MASK_LOW)) begin
            nxt_mask_low = hwdata[7:0];
        end
        if (addr_is(ap_ff, epiu_pkg::ADDR_MASK_HIGH)) begin
            nxt_mask_high = hwdata[7:0];
        end

        line_set[epiu_pkg::BIT_LINE_A] = edge_hit(sense_a, sync_ff[epiu_pkg::PIN_LINE_A],
                                                  prev_ff[epiu_pkg::PIN_LINE_A]);
        line_set[epiu_pkg::BIT_LINE_B] = edge_hit(sense_b, sync_ff[epiu_pkg::PIN_LINE_B],
                                                  prev_ff[epiu_pkg::PIN_LINE_B]);
        bank_set[epiu_pkg::BIT_LOW_BANK]  = bank_hit(sync_ff[epiu_pkg::PIN_BANK_LSB +: 8],
                                                     prev_ff[epiu_pkg::PIN_BANK_LSB +: 8],
                                                     mask_low_ff);
        bank_set[epiu_pkg::BIT_HIGH_BANK] = bank_hit(sync_ff[epiu_pkg::PIN_BANK_LSB + 8 +: 8],
                                                     prev_ff[epiu_pkg::PIN_BANK_LSB + 8 +: 8],
                                                     mask_high_ff);

        line_clr = {vector_taken.line_b, vector_taken.line_a};
        bank_clr = {vector_taken.high_bank, vector_taken.low_bank};
        if (addr_is(ap_ff, epiu_pkg::ADDR_FLAGS)) begin
            line_clr = line_clr | hwdata[1:0];
        end
        if (addr_is(ap_ff, epiu_pkg::ADDR_BANK_FLAGS)) begin
            bank_clr = bank_clr | hwdata[1:0];
        end

        line_low[epiu_pkg::BIT_LINE_A] =
            (nxt_sense[epiu_pkg::SENSE_A_LSB +: 2] == epiu_pkg::SENSE_LOW);
        line_low[epiu_pkg::BIT_LINE_B] =
            (nxt_sense[epiu_pkg::SENSE_B_LSB +: 2] == epiu_pkg::SENSE_LOW);

        nxt_flags      = (line_set | (flags_ff & ~line_clr)) & ~line_low;
        nxt_bank_flags = bank_set | (bank_flags_ff & ~bank_clr);
    end

    // ==========================================================
    // Read data, taken from next values so a read right after a write
    // returns the written data.

    always_comb begin
        nxt_hrdata = '0;
        if (ap_take && !hwrite) begin
            unique case (haddr)
                epiu_pkg::ADDR_SENSE:      nxt_hrdata = {28'h0, nxt_sense};
                epiu_pkg::ADDR_ENABLE:     nxt_hrdata = {30'h0, nxt_enable};
                epiu_pkg::ADDR_FLAGS:      nxt_hrdata = {30'h0, nxt_flags};
                epiu_pkg::ADDR_BANK_EN:    nxt_hrdata = {30'h0, nxt_bank_en};
                epiu_pkg::ADDR_BANK_FLAGS: nxt_hrdata = {30'h0, nxt_bank_flags};
                epiu_pkg::ADDR_MASK_LOW:   nxt_hrdata = {24'h0, nxt_mask_low};
                epiu_pkg::ADDR_MASK_HIGH:  nxt_hrdata = {24'h0, nxt_mask_high};
                default:                   nxt_hrdata = '0;
            endcase
        end
    end

    // ==========================================================
    // Requests to the core, registered from next state

    epiu_pkg::epiu_irq_t irq_ff;
    epiu_pkg::epiu_irq_t nxt_irq;
    logic [1:0]          level_req;

    always_comb begin
        level_req[epiu_pkg::BIT_LINE_A] = line_low[epiu_pkg::BIT_LINE_A] &&
                                          !sync_ff[epiu_pkg::PIN_LINE_A];
        level_req[epiu_pkg::BIT_LINE_B] = line_low[epiu_pkg::BIT_LINE_B] &&
                                          !sync_ff[epiu_pkg::PIN_LINE_B];
        nxt_irq.line_a    = global_int_enable && nxt_enable[epiu_pkg::BIT_LINE_A] &&
                            (nxt_flags[epiu_pkg::BIT_LINE_A] || level_req[epiu_pkg::BIT_LINE_A]);
        nxt_irq.line_b    = global_int_enable && nxt_enable[epiu_pkg::BIT_LINE_B] &&
                            (nxt_flags[epiu_pkg::BIT_LINE_B] || level_req[epiu_pkg::BIT_LINE_B]);
        nxt_irq.low_bank  = global_int_enable && nxt_bank_en[epiu_pkg::BIT_LOW_BANK] &&
                            nxt_bank_flags[epiu_pkg::BIT_LOW_BANK];
        nxt_irq.high_bank = global_int_enable && nxt_bank_en[epiu_pkg::BIT_HIGH_BANK] &&
                            nxt_bank_flags[epiu_pkg::BIT_HIGH_BANK];
    end

    assign irq_request = irq_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_ff         <= '0;
            hrdata_ff     <= '0;
            sense_ff      <= epiu_pkg::SENSE_RESET;
            enable_ff     <= epiu_pkg::CTRL_RESET;
            flags_ff      <= epiu_pkg::CTRL_RESET;
            bank_en_ff    <= epiu_pkg::CTRL_RESET;
            bank_flags_ff <= epiu_pkg::CTRL_RESET;
            mask_low_ff   <= epiu_pkg::MASK_RESET;
            mask_high_ff  <= epiu_pkg::MASK_RESET;
            irq_ff        <= '0;
        end else begin
            ap_ff         <= nxt_ap;
            hrdata_ff     <= nxt_hrdata;
            sense_ff      <= nxt_sense;
            enable_ff     <= nxt_enable;
            flags_ff      <= nxt_flags;
            bank_en_ff    <= nxt_bank_en;
            bank_flags_ff <= nxt_bank_flags;
            mask_low_ff   <= nxt_mask_low;
            mask_high_ff  <= nxt_mask_high;
            irq_ff        <= nxt_irq;
        end
    end

    // ==========================================================
    // Clockless wake path. It compares raw pins with the settled samples,
    // so it works while the clock is stopped; it is glitch-prone and meant
    // only to start the clock, never to be sampled as an event.

    logic [15:0] raw_change;

    assign raw_change = (change_watch_pin ^ sync_ff[epiu_pkg::PIN_BANK_LSB +: 16]) &
                        {{8{bank_en_ff[epiu_pkg::BIT_HIGH_BANK]}} & mask_high_ff,
                         {8{bank_en_ff[epiu_pkg::BIT_LOW_BANK]}} & mask_low_ff};

    assign wake_request = (|raw_change) ||
        (!request_line_a && enable_ff[epiu_pkg::BIT_LINE_A] &&
         (sense_a == epiu_pkg::SENSE_LOW)) ||
        (!request_line_b && enable_ff[epiu_pkg::BIT_LINE_B] &&
         (sense_b == epiu_pkg::SENSE_LOW));

    // ==========================================================
    // Assertions

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_reserved_zero: assert property (
        (ap_take && !hwrite && (haddr == epiu_pkg::ADDR_FLAGS)) |=> (hrdata[31:2] == 30'h0))
        else $error("Reserved flag bits read non-zero.");

    a_sense_store: assert property (
        addr_is(ap_ff, epiu_pkg::ADDR_SENSE) |=> (sense_ff == $past(hwdata[3:0])))
        else $error("Sense register did not take written value.");

    a_fall_sets: assert property (
        (sense_a == epiu_pkg::SENSE_FALL && prev_ff[0] && !sync_ff[0] &&
         !addr_is(ap_ff, epiu_pkg::ADDR_SENSE)) |=> flags_ff[0])
         else $error("Falling edge did not set line A flag.");

    a_req_gated: assert property (
        irq_request.line_a |-> ($past(global_int_enable) && enable_ff[0]))
        else $error("Line A request without enables.");

    a_pulse_seen: assert property (
        (sense_b == epiu_pkg::SENSE_ANY && !wr_any && $changed(request_line_b))
        |-> ##3 flags_ff[1])
        else $error("Line B change missed.");

    a_level_zero: assert property (
        (sense_a == epiu_pkg::SENSE_LOW) |-> !flags_ff[0])
        else $error("Line A flag set in low-level mode.");

    a_w1c_clear: assert property (
        (addr_is(ap_ff, epiu_pkg::ADDR_BANK_FLAGS) && hwdata[0] && !bank_set[0])
        |=> !bank_flags_ff[0])
        else $error("Write-one did not clear low bank flag.");

    a_set_wins: assert property (
        (bank_set[1] && bank_clr[1]) |=> bank_flags_ff[1])
        else $error("Clear beat a set on high bank flag.");

    a_vector_clear: assert property (
        (vector_taken.low_bank && !bank_set[0]) |=> !bank_flags_ff[0])
        else $error("Vectoring did not clear low bank flag.");

    a_level_hold: assert property (
        (sense_a == epiu_pkg::SENSE_LOW && enable_ff[0] && global_int_enable &&
         !sync_ff[0] && !wr_any) |=> irq_request.line_a)
        else $error("Low level did not request.");

    a_mask_gate: assert property (
        $rose(bank_flags_ff[0]) |->
        $past(|((sync_ff[9:2] ^ prev_ff[9:2]) & mask_low_ff)))
        else $error("Low bank flag set by a masked pin.");

    c_line_a_req: cover property (irq_request.line_a ##1 vector_taken.line_a);
    c_high_bank:  cover property ($rose(irq_request.high_bank));
    c_rise_b:     cover property (sense_b == epiu_pkg::SENSE_RISE && $rose(flags_ff[1]));
    c_set_clear:  cover property (bank_set[1] && bank_clr[1]);

endmodule

// >>> rtl/epiu_pkg.sv
// Shared constants and types for the external pin interrupt unit.
package epiu_pkg;

    // ==========================================================
    // Bus widths and transfer codes
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

    // ==========================================================
    // Register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_MASK_LOW   = 8'h6b;
    localparam logic [7:0]  IDX_MASK_HIGH  = 8'h6c;
    localparam logic [7:0]  IDX_SENSE      = 8'h69;
    localparam logic [7:0]  IDX_BANK_EN    = 8'h68;
    localparam logic [7:0]  IDX_ENABLE     = 8'h3d;
    localparam logic [7:0]  IDX_FLAGS      = 8'h3c;
    localparam logic [7:0]  IDX_BANK_FLAGS = 8'h3b;

    localparam logic [ADDR_W-1:0] ADDR_MASK_LOW   = {2'h0, IDX_MASK_LOW, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MASK_HIGH  = {2'h0, IDX_MASK_HIGH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SENSE      = {2'h0, IDX_SENSE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BANK_EN    = {2'h0, IDX_BANK_EN, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_ENABLE     = {2'h0, IDX_ENABLE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FLAGS      = {2'h0, IDX_FLAGS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BANK_FLAGS = {2'h0, IDX_BANK_FLAGS, 2'h0};

    // ==========================================================
    // Field positions and reset values
    localparam int          SENSE_A_LSB   = 0;
    localparam int          SENSE_B_LSB   = 2;
    localparam int          BIT_LINE_A    = 0;
    localparam int          BIT_LINE_B    = 1;
    localparam int          BIT_LOW_BANK  = 0;
    localparam int          BIT_HIGH_BANK = 1;
    localparam int          PIN_LINE_A    = 0;
    localparam int          PIN_LINE_B    = 1;
    localparam int          PIN_BANK_LSB  = 2;
    localparam int          NUM_PINS      = 18;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [3:0]  SENSE_RESET   = 4'h0;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epiu_sense_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } epiu_ahb_ap_t;

    typedef struct packed {
        logic high_bank;
        logic low_bank;
        logic line_b;
        logic line_a;
    } epiu_irq_t;

endpackage
